// >>> bench/cmp_host_model.sv
// link controller model issuing register strobes
`timescale 1ns/1ns
module cmp_host_model (
  input wire logic sys_clk,
  output logic regWrite,
  output logic regRead,
  output logic [6:0] regAddr,
  output logic [15:0] regWrData,
  input wire logic [15:0] regRdData,
  input wire logic regRdValid
);
  initial begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 7'h00;
    regWrData = 16'h0000;
  end
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWrite <= 1'b0;
    // stale data inverted so it never passes for valid
    regWrData <= ~d;
  endtask : wr
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRead <= 1'b0;
    // the answer stands for one cycle only, so take it mid-cycle
    @(negedge sys_clk);
    d = (regRdValid === 1'b1) ? regRdData : 16'hdead;
  endtask : rd
endmodule : cmp_host_model

// >>> bench/cmp_regs_checker.sv
// port assertions for the mixer/power register bank
`timescale 1ns/1ns
module cmp_regs_checker (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [6:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic [15:0] regRdData,
  input wire logic regRdValid,
  input wire logic [cmp_pkg::RUN_W-1:0] blockRun,
  input wire logic sleepMode,
  input wire logic [15:0] micPathRouting,
  input wire logic [15:0] recordMixerMutes,
  input wire logic variableRateAudio,
  input wire logic [15:0] playbackRateField,
  input wire logic [15:0] powerEnableBlocks
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  // a second request write right behind would mask the first
  sequence pdWrite;
    regWrite && regAddr == 7'h26 ##1 !(regWrite && regAddr == 7'h26);
  endsequence
  AST_ODD_READ: assert property (regRead && regAddr[0] |=> regRdValid && regRdData == 16'h0000)
    else $error("odd address read not zero");
  AST_SLEEP: assert property (pdWrite |=> sleepMode == $past(regWrData[12], 2))
    else $error("sleep does not follow link request");
  AST_RATE_FORCE: assert property (regWrite && regAddr == 7'h2c && !variableRateAudio && regWrData != 16'h0000
    |=> playbackRateField == 16'hbb80) else $error("fixed rate not forced");
  AST_VRA: assert property ($changed(variableRateAudio) |-> $past(regWrite) && $past(regAddr) == 7'h2a)
    else $error("variable rate changed without write");
  AST_ROUTE_RSV: assert property ((micPathRouting & 16'h0f0f) == 16'h0000)
    else $error("routing reserved bits set");
  AST_RSV: assert property ((recordMixerMutes & 16'h8080) == 16'h0000)
    else $error("record mixer reserved bits set");
  AST_LINK_GATE: assert property (sleepMode |-> (blockRun & 9'h013) == 9'h000)
    else $error("link request leaves blocks running");
  AST_DAC_EN: assert property (blockRun[1] |-> $past(powerEnableBlocks[9]) || $past(powerEnableBlocks[8]))
    else $error("dac runs without enable");
  AST_STATUS: assert property (regRdValid && $past(regAddr) == 7'h26
    |-> regRdData[1:0] == ~regRdData[9:8] && regRdData[7:4] == 4'h0) else $error("ready flags wrong");
endmodule : cmp_regs_checker
bind cmp_mixer_power_regs cmp_regs_checker i_cmp_regs_checker (.sys_clk, .sys_rst, .regWrite, .regRead,
  .regAddr, .regWrData, .regRdData, .regRdValid, .blockRun, .sleepMode, .micPathRouting, .recordMixerMutes,
  .variableRateAudio, .playbackRateField, .powerEnableBlocks);

// >>> bench/tb_top.sv
// self-checking bench for the mixer/power register bank
`timescale 1ns/1ns
module tb_top;
  logic sys_clk;
  logic sys_rst;
  logic regWrite;
  logic regRead;
  logic [6:0] regAddr;
  logic [15:0] regWrData;
  logic [15:0] regRdData;
  logic regRdValid;
  logic [cmp_pkg::RUN_W-1:0] blockRun;
  logic sleepMode;
  logic variableRateAudio;
  logic [15:0] micPathRouting;
  logic [15:0] recordGain;
  logic [15:0] recordMixerMutes;
  logic [15:0] outputSourceSelect;
  logic [15:0] microphoneBoostBias;
  logic [15:0] playbackRateField;
  logic [15:0] recordRateField;
  logic [15:0] powerEnableBias;
  logic [15:0] powerEnableBlocks;
  int num_errors;
  int n_tests;
  cmp_mixer_power_regs i_cmp_mixer_power_regs (.sys_clk, .sys_rst, .regWrite, .regRead, .regAddr, .regWrData,
    .regRdData, .regRdValid, .blockRun, .sleepMode, .micPathRouting, .recordGain, .recordMixerMutes,
    .outputSourceSelect, .microphoneBoostBias, .variableRateAudio, .playbackRateField,
    .recordRateField, .powerEnableBias, .powerEnableBlocks);
  cmp_host_model i_cmp_host_model (.sys_clk, .regWrite, .regRead, .regAddr, .regWrData, .regRdData, .regRdValid);
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic rc(input logic [6:0] a, input logic [15:0] exp);
    logic [15:0] v;
    i_cmp_host_model.rd(a, v);
    chk($sformatf("reg %h", a), v, exp);
  endtask : rc
  task automatic t_reset;
    logic [6:0] a [11] = '{7'h10, 7'h12, 7'h14, 7'h1c, 7'h22, 7'h26, 7'h2a, 7'h2c, 7'h32, 7'h3a, 7'h3c};
    logic [15:0] r [11] = '{16'he0e0, 16'hf58b, 16'h7f7f, 16'h0, 16'h0, 16'hef00, 16'h0, 16'hbb80,
      16'hbb80, 16'h0, 16'h0};
    for (int i = 0; i < 11; i++) rc(a[i], r[i]);
    rc(7'h11, 16'h0000);
    rc(7'h40, 16'h0000);
  endtask : t_reset
  task automatic t_masks;
    logic [6:0] a [10] = '{7'h10, 7'h12, 7'h14, 7'h1c, 7'h22, 7'h2a, 7'h2c, 7'h32, 7'h3a, 7'h3c};
    logic [15:0] m [10] = '{16'hf0f0, 16'hffff, 16'h7f7f, 16'hfbd0, 16'h0f33, 16'h1, 16'hffff, 16'hffff,
      16'hffff, 16'hffff};
    for (int i = 0; i < 10; i++) begin
      i_cmp_host_model.wr(a[i], 16'hffff);
      rc(a[i], m[i]);
    end
    // register outputs must match what reads back
    chk("routeOut", micPathRouting, 16'hf0f0);
    chk("gainOut", recordGain, 16'hffff);
    chk("mixOut", recordMixerMutes, 16'h7f7f);
    chk("selOut", outputSourceSelect, 16'hfbd0);
    chk("micOut", microphoneBoostBias, 16'h0f33);
    chk("playOut", playbackRateField, 16'hffff);
    chk("recOut", recordRateField, 16'hffff);
    chk("biasOut", powerEnableBias, 16'hffff);
    chk("blkOut", powerEnableBlocks, 16'hffff);
  endtask : t_masks
  task automatic t_rate;
    i_cmp_host_model.wr(7'h2a, 16'h0000);
    i_cmp_host_model.wr(7'h2c, 16'h1f40);
    rc(7'h2c, 16'hbb80);
    i_cmp_host_model.wr(7'h2c, 16'h0000);
    rc(7'h2c, 16'h0000);
    i_cmp_host_model.wr(7'h32, 16'hac44);
    rc(7'h32, 16'hac44);
    i_cmp_host_model.wr(7'h2a, 16'h0001);
    #1;
    chk("vra", 16'(variableRateAudio), 16'h0001);
    i_cmp_host_model.wr(7'h2c, 16'h1f40);
    rc(7'h2c, 16'h1f40);
  endtask : t_rate
  task automatic t_power;
    logic [8:0] m [8] = '{9'h001, 9'h002, 9'h044, 9'h04f, 9'h013, 9'h033, 9'h0c0, 9'h100};
    // status byte is read-only, so the written ones must not show
    i_cmp_host_model.wr(7'h26, 16'h00ff);
    rc(7'h26, 16'h000f);
    chk("runAll", 16'(blockRun), 16'h01ff);
    for (int i = 0; i < 8; i++) begin
      i_cmp_host_model.wr(7'h26, 16'h0100 << i);
      repeat (2) @(posedge sys_clk);
      #1;
      chk("run", 16'(blockRun), 16'(9'h1ff & ~m[i]));
      chk("sleep", 16'(sleepMode), 16'(i == 4));
    end
    i_cmp_host_model.wr(7'h26, 16'h0000);
    i_cmp_host_model.wr(7'h3c, 16'h0000);
    repeat (2) @(posedge sys_clk);
    #1;
    chk("runOff", 16'(blockRun), 16'h0030);
  endtask : t_power
  task automatic final_report;
    $display("tests %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report
  initial begin
    num_errors = 0;
    n_tests = 0;
    sys_rst = 1'b1;
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_masks();
    t_rate();
    t_power();
    final_report();
  end
  // whole run is about 140 cycles
  initial begin
    #100000;
    num_errors++;
    final_report();
  end
endmodule : tb_top

// >>> src/cmp_mixer_power_regs.sv
// mixer routing, record gain, power-down and sample-rate register bank
`timescale 1ns/1ns
//
// Contract
// - mic routing has six mute bits, reset e0e0
// - mic differential enables at bits 12 and 4
// - record gain fields 11:7 and 4:0, reset 0b
// - four record-gain mixer mutes, reset f58b
// - zero-cross enables at bits 6 and 5
// - record mixer mutes 14:8 and 6:0, reset 7f7f
// - speaker input selects at 15:14 and 12:11
// - bit 13 picks class AB or D
// - headphone selects bits 9,8; mono select 7:6
// - bit 4 right amp source; reset zero
// - mic boost fields at 11:10 and 9:8
// - bias selects bits 5,4; threshold 1:0
// - eight power-down requests 15:8, reset ef00
// - requests gate blocks per truth table
// - read-only ready flags in bits 3:0
// - tone register holds only variable-rate enable
// - playback rate 16-bit, reset bb80
// - without variable rate, nonzero writes become bb80
// - record rate 16-bit, reset bb80
// - bias power register, reset zero
// - block power register, reset zero
// - block runs when request clear and enabled
// - odd or unimplemented reads return zero
// - link power-down request enters sleep
module cmp_mixer_power_regs (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [6:0] regAddr,
  input wire logic [15:0] regWrData,
  output logic [15:0] regRdData,
  output logic regRdValid,
  output logic [cmp_pkg::RUN_W-1:0] blockRun,
  output logic sleepMode,
  output logic [15:0] micPathRouting,
  output logic [15:0] recordGain,
  output logic [15:0] recordMixerMutes,
  output logic [15:0] outputSourceSelect,
  output logic [15:0] microphoneBoostBias,
  output logic variableRateAudio,
  output logic [15:0] playbackRateField,
  output logic [15:0] recordRateField,
  output logic [15:0] powerEnableBias,
  output logic [15:0] powerEnableBlocks
);
  cmp_pkg::cmp_state_t state_q;
  cmp_pkg::cmp_state_t state_d;
  cmp_pd_if pd ();
  logic [15:0] pwrStatus;
  logic [15:0] rdMux;

  assign pd.pwrReq = state_q.pwrReq;
  assign pd.pwrBlk = state_q.pwrBlk;
  assign pd.pwrBias = state_q.pwrBias;

  cmp_power_gate u_gate (
    .pd(pd)
  );

  // ready flags: dac/adc are the inverse of their requests, vref and mixer follow run state
  assign pwrStatus = {state_q.pwrReq, 4'h0, pd.run[cmp_pkg::RUN_VREF], pd.run[cmp_pkg::RUN_MIX],
    !state_q.pwrReq[cmp_pkg::PR_DAC], !state_q.pwrReq[cmp_pkg::PR_ADC]};

  always_comb begin
    rdMux = 16'h0000;
    // odd addresses never match an even offset, so they read zero
    case (regAddr)
      cmp_pkg::ADDR_MIC_ROUTE: rdMux = state_q.micRoute;
      cmp_pkg::ADDR_REC_GAIN: rdMux = state_q.recGain;
      cmp_pkg::ADDR_REC_MIX: rdMux = state_q.recMix;
      cmp_pkg::ADDR_OUT_SEL: rdMux = state_q.outSel;
      cmp_pkg::ADDR_MIC_CTRL: rdMux = state_q.micCtrl;
      cmp_pkg::ADDR_PWR_DOWN: rdMux = pwrStatus;
      cmp_pkg::ADDR_VRA: rdMux = {15'h0000, state_q.variable_rate_audio};
      cmp_pkg::ADDR_PLAY_RATE: rdMux = state_q.playRate;
      cmp_pkg::ADDR_REC_RATE: rdMux = state_q.recRate;
      cmp_pkg::ADDR_PWR_BIAS: rdMux = state_q.pwrBias;
      cmp_pkg::ADDR_PWR_BLK: rdMux = state_q.pwrBlk;
      default: rdMux = 16'h0000;
    endcase
  end

  always_comb begin
    state_d = state_q;
    state_d.rdValid = regRead;
    state_d.rdData = regRead ? rdMux : 16'h0000;
    if (regWrite) begin
      case (regAddr)
        cmp_pkg::ADDR_MIC_ROUTE: state_d.micRoute = regWrData & cmp_pkg::MASK_MIC_ROUTE;
        cmp_pkg::ADDR_REC_GAIN: state_d.recGain = regWrData & cmp_pkg::MASK_REC_GAIN;
        cmp_pkg::ADDR_REC_MIX: state_d.recMix = regWrData & cmp_pkg::MASK_REC_MIX;
        cmp_pkg::ADDR_OUT_SEL: state_d.outSel = regWrData & cmp_pkg::MASK_OUT_SEL;
        cmp_pkg::ADDR_MIC_CTRL: state_d.micCtrl = regWrData & cmp_pkg::MASK_MIC_CTRL;
        // status bits 7:0 are read-only, so only the request byte is stored
        cmp_pkg::ADDR_PWR_DOWN: state_d.pwrReq = regWrData[15:cmp_pkg::PR_LSB];
        cmp_pkg::ADDR_VRA: state_d.variable_rate_audio = |(regWrData & cmp_pkg::MASK_VRA);
        cmp_pkg::ADDR_PLAY_RATE: begin
          // forced rate uses the enable as it stands before this write
          if (!state_q.variable_rate_audio && regWrData != 16'h0000) begin
            state_d.playRate = cmp_pkg::RST_RATE;
          end else begin
            state_d.playRate = regWrData;
          end
        end
        cmp_pkg::ADDR_REC_RATE: state_d.recRate = regWrData;
        cmp_pkg::ADDR_PWR_BIAS: state_d.pwrBias = regWrData & cmp_pkg::MASK_PWR_BIAS;
        cmp_pkg::ADDR_PWR_BLK: state_d.pwrBlk = regWrData & cmp_pkg::MASK_PWR_BLK;
        default: state_d.rdValid = regRead;
      endcase
    end
    state_d.run = pd.run;
    // sleep is entered only by the link request; the controller must write 1 to it
    state_d.sleep = state_q.pwrReq[cmp_pkg::PR_LINK];
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q.micRoute <= cmp_pkg::RST_MIC_ROUTE;
      state_q.recGain <= cmp_pkg::RST_REC_GAIN;
      state_q.recMix <= cmp_pkg::RST_REC_MIX;
      state_q.outSel <= cmp_pkg::RST_OUT_SEL;
      state_q.micCtrl <= cmp_pkg::RST_MIC_CTRL;
      state_q.pwrReq <= cmp_pkg::RST_PWR_REQ;
      state_q.variable_rate_audio <= 1'b0;
      state_q.playRate <= cmp_pkg::RST_RATE;
      state_q.recRate <= cmp_pkg::RST_RATE;
      state_q.pwrBias <= cmp_pkg::RST_ZERO;
      state_q.pwrBlk <= cmp_pkg::RST_ZERO;
      state_q.rdData <= 16'h0000;
      state_q.rdValid <= 1'b0;
      state_q.run <= '0;
      state_q.sleep <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  assign regRdData = state_q.rdData;
  assign regRdValid = state_q.rdValid;
  assign blockRun = state_q.run;
  assign sleepMode = state_q.sleep;
  assign micPathRouting = state_q.micRoute;
  assign recordGain = state_q.recGain;
  assign recordMixerMutes = state_q.recMix;
  assign outputSourceSelect = state_q.outSel;
  assign microphoneBoostBias = state_q.micCtrl;
  assign variableRateAudio = state_q.variable_rate_audio;
  assign playbackRateField = state_q.playRate;
  assign recordRateField = state_q.recRate;
  assign powerEnableBias = state_q.pwrBias;
  assign powerEnableBlocks = state_q.pwrBlk;
endmodule : cmp_mixer_power_regs

// >>> src/cmp_pd_if.sv
// power-down request and run-status carrier between bank and gating logic
`timescale 1ns/1ns
interface cmp_pd_if;
  logic [7:0] pwrReq;
  logic [15:0] pwrBlk;
  logic [15:0] pwrBias;
  logic [cmp_pkg::RUN_W-1:0] run;
  modport bank (output pwrReq, output pwrBlk, output pwrBias, input run);
  modport gate (input pwrReq, input pwrBlk, input pwrBias, output run);
endinterface : cmp_pd_if

// >>> src/cmp_pkg.sv
// constants and types shared by the mixer/power register bank
package cmp_pkg;
  localparam logic [6:0] ADDR_MIC_ROUTE = 7'h10;
  localparam logic [6:0] ADDR_REC_GAIN = 7'h12;
  localparam logic [6:0] ADDR_REC_MIX = 7'h14;
  localparam logic [6:0] ADDR_OUT_SEL = 7'h1c;
  localparam logic [6:0] ADDR_MIC_CTRL = 7'h22;
  localparam logic [6:0] ADDR_PWR_DOWN = 7'h26;
  localparam logic [6:0] ADDR_VRA = 7'h2a;
  localparam logic [6:0] ADDR_PLAY_RATE = 7'h2c;
  localparam logic [6:0] ADDR_REC_RATE = 7'h32;
  localparam logic [6:0] ADDR_PWR_BIAS = 7'h3a;
  localparam logic [6:0] ADDR_PWR_BLK = 7'h3c;

  localparam logic [15:0] RST_MIC_ROUTE = 16'he0e0;
  localparam logic [15:0] RST_REC_GAIN = 16'hf58b;
  localparam logic [15:0] RST_REC_MIX = 16'h7f7f;
  localparam logic [15:0] RST_OUT_SEL = 16'h0000;
  localparam logic [15:0] RST_MIC_CTRL = 16'h0000;
  localparam logic [7:0] RST_PWR_REQ = 8'hef;
  localparam logic [15:0] RST_RATE = 16'hbb80;
  localparam logic [15:0] RST_ZERO = 16'h0000;

  // writable bit masks; other bits are reserved and read as zero
  localparam logic [15:0] MASK_MIC_ROUTE = 16'hf0f0;
  localparam logic [15:0] MASK_REC_GAIN = 16'hffff;
  localparam logic [15:0] MASK_REC_MIX = 16'h7f7f;
  localparam logic [15:0] MASK_OUT_SEL = 16'hfbd0;
  localparam logic [15:0] MASK_MIC_CTRL = 16'h0f33;
  localparam logic [15:0] MASK_VRA = 16'h0001;
  localparam logic [15:0] MASK_PWR_BIAS = 16'hffff;
  localparam logic [15:0] MASK_PWR_BLK = 16'hffff;

  // power-down request positions inside the 8-bit request field
  localparam int PR_ADC = 0;
  localparam int PR_DAC = 1;
  localparam int PR_MIX = 2;
  localparam int PR_MIXREF = 3;
  localparam int PR_LINK = 4;
  localparam int PR_CLK = 5;
  localparam int PR_HPMONO = 6;
  localparam int PR_SPK = 7;
  localparam int PR_LSB = 8;

  // block-enable positions in the block power register; PBI_MAIN is in the bias power register
  localparam int PB_DAC_L = 9;
  localparam int PB_DAC_R = 8;
  localparam int PB_ADC_L = 7;
  localparam int PB_ADC_R = 6;
  localparam int PB_HP_L = 5;
  localparam int PB_HP_R = 4;
  localparam int PB_VREF = 13;
  localparam int PB_CLSAB = 14;
  localparam int PB_SPK = 3;
  localparam int PB_MONO = 2;
  localparam int PBI_MAIN = 1;

  // gated block outputs (run vector)
  localparam int RUN_ADC = 0;
  localparam int RUN_DAC = 1;
  localparam int RUN_MIX = 2;
  localparam int RUN_VREF = 3;
  localparam int RUN_LINK = 4;
  localparam int RUN_CLK = 5;
  localparam int RUN_HP = 6;
  localparam int RUN_MONO = 7;
  localparam int RUN_SPK = 8;
  localparam int RUN_W = 9;

  typedef struct packed {
    logic [15:0] micRoute;
    logic [15:0] recGain;
    logic [15:0] recMix;
    logic [15:0] outSel;
    logic [15:0] micCtrl;
    logic [7:0] pwrReq;
    logic variable_rate_audio;
    logic [15:0] playRate;
    logic [15:0] recRate;
    logic [15:0] pwrBias;
    logic [15:0] pwrBlk;
    logic [15:0] rdData;
    logic rdValid;
    logic [RUN_W-1:0] run;
    logic sleep;
  } cmp_state_t;
endpackage : cmp_pkg

// >>> src/cmp_power_gate.sv
// combines standard power-down requests with extended block enables
`timescale 1ns/1ns
module cmp_power_gate (
  cmp_pd_if.gate pd
);
  logic [7:0] r;
  logic [15:0] b;
  assign r = pd.pwrReq;
  assign b = pd.pwrBlk;
  // each block except link and clock runs only when no gating request is set and its enable is set
  assign pd.run[cmp_pkg::RUN_ADC] = !(r[cmp_pkg::PR_ADC] | r[cmp_pkg::PR_MIXREF] | r[cmp_pkg::PR_LINK] |
    r[cmp_pkg::PR_CLK]) & (b[cmp_pkg::PB_ADC_L] | b[cmp_pkg::PB_ADC_R]);
  assign pd.run[cmp_pkg::RUN_DAC] = !(r[cmp_pkg::PR_DAC] | r[cmp_pkg::PR_MIXREF] | r[cmp_pkg::PR_LINK] |
    r[cmp_pkg::PR_CLK]) & (b[cmp_pkg::PB_DAC_L] | b[cmp_pkg::PB_DAC_R]);
  assign pd.run[cmp_pkg::RUN_MIX] = !(r[cmp_pkg::PR_MIX] | r[cmp_pkg::PR_MIXREF]) &
    (b[cmp_pkg::PB_HP_L] | b[cmp_pkg::PB_HP_R] | b[cmp_pkg::PB_SPK] | b[cmp_pkg::PB_MONO]);
  assign pd.run[cmp_pkg::RUN_VREF] = !r[cmp_pkg::PR_MIXREF] & b[cmp_pkg::PB_VREF] &
    pd.pwrBias[cmp_pkg::PBI_MAIN];
  // link and internal clock have no extended enable
  assign pd.run[cmp_pkg::RUN_LINK] = !(r[cmp_pkg::PR_LINK] | r[cmp_pkg::PR_CLK]);
  assign pd.run[cmp_pkg::RUN_CLK] = !r[cmp_pkg::PR_CLK];
  assign pd.run[cmp_pkg::RUN_HP] = !(r[cmp_pkg::PR_MIX] | r[cmp_pkg::PR_MIXREF] | r[cmp_pkg::PR_HPMONO]) &
    (b[cmp_pkg::PB_HP_L] | b[cmp_pkg::PB_HP_R]);
  assign pd.run[cmp_pkg::RUN_MONO] = !r[cmp_pkg::PR_HPMONO] & b[cmp_pkg::PB_MONO];
  assign pd.run[cmp_pkg::RUN_SPK] = !r[cmp_pkg::PR_SPK] & b[cmp_pkg::PB_CLSAB];
endmodule : cmp_power_gate
